// ===== design/aimrc_top.sv
// The APB interface to the registers and the register offsets were decided locally.
`include "aimrc_cfg.svh"

`default_nettype none

module aimrc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output aimrc_pkg::aimrc_fe_req_t fe_req,
    input wire logic fe_done,
    input wire logic [11:0] fe_code,
    input wire logic [3:0] is_valid,
    input wire logic [3:0][11:0] is_code,
    output logic [3:0] loop_valid,
    output logic [3:0][11:0] loop_code
);
    import aimrc_pkg::*;

    aimrc_state_t s_q;
    aimrc_state_t s_d;

    logic acc;
    logic wr_now;
    logic start_req;
    logic clr_req;
    logic [1:0] req_chan;
    logic [1:0] pair;
    logic [3:0] mult;
    logic [31:0] rd_word;
    logic rd_err;

    // range code to full-scale multiple of the reference
    function automatic logic [3:0] range_mult(input logic [1:0] rng);
        logic [3:0] m;
        m = `AIMRC_MULT_X2;
        if (rng == `AIMRC_RANGE_X4)
        begin
            m = `AIMRC_MULT_X4;
        end
        else if (rng == `AIMRC_RANGE_X1)
        begin
            m = `AIMRC_MULT_X1;
        end
        return m;
    endfunction

    // read mux; answers one cycle ahead of pready
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr == `AIMRC_OFF_CFG)
        begin
            rd_word[`AIMRC_CFG_RANGE_LSB +: 2] = s_q.cfg.range;
            rd_word[`AIMRC_CFG_DIFF_BIT] = s_q.cfg.diff;
            rd_word[`AIMRC_CFG_PSEUDO_BIT] = s_q.cfg.pseudo;
            rd_word[`AIMRC_CFG_ALLOC_LSB +: 2] = s_q.cfg.alloc;
            rd_word[`AIMRC_CFG_ROUTE_LSB +: 4] = s_q.cfg.route;
        end
        else if (paddr == `AIMRC_OFF_CTRL)
        begin
            // control bits are self-clearing and read as zero
            rd_word = 32'h0000_0000;
        end
        else if (paddr == `AIMRC_OFF_STATUS)
        begin
            rd_word[`AIMRC_ST_BUSY_BIT] = (s_q.fsm != AIMRC_IDLE);
            rd_word[`AIMRC_ST_DONE_BIT] = s_q.done;
            rd_word[`AIMRC_ST_RANGE_LSB +: 2] = s_q.act_range;
            rd_word[`AIMRC_ST_DIFF_BIT] = s_q.act_diff;
            rd_word[`AIMRC_ST_STEP_LSB +: 4] = s_q.fe.step_units;
        end
        else if (paddr >= `AIMRC_OFF_RESULT0 && paddr <= `AIMRC_OFF_RESULT3
            && paddr[1:0] == 2'b00)
        begin
            rd_word[11:0] = s_q.result[paddr[3:2]];
        end
        else if (paddr >= `AIMRC_OFF_ISENSE0 && paddr <= `AIMRC_OFF_ISENSE3
            && paddr[1:0] == 2'b00)
        begin
            rd_word[11:0] = s_q.isense[paddr[3:2]];
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    always_comb
    begin
        acc = psel && penable;
        // a write lands only on the edge where the master sees pready
        wr_now = acc && s_q.pready && pwrite && !s_q.pslverr;
        start_req = wr_now && paddr == `AIMRC_OFF_CTRL && pwdata[`AIMRC_CTRL_START_BIT];
        clr_req = wr_now && paddr == `AIMRC_OFF_CTRL && pwdata[`AIMRC_CTRL_CLR_BIT];
        req_chan = pwdata[`AIMRC_CTRL_CHAN_LSB +: 2];
        pair = {1'b0, req_chan[0]};
        mult = range_mult(s_q.cfg.range);
    end

    always_comb
    begin
        s_d = s_q;
        s_d.fe.start = 1'b0;
        s_d.loop_valid = 4'h0;
        s_d.pready = 1'b0;

        // one wait state per access
        if (acc && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
            s_d.pslverr = rd_err;
        end

        if (wr_now && paddr == `AIMRC_OFF_CFG)
        begin
            // the live copy only; a running conversion keeps its latched setup
            s_d.cfg.range = pwdata[`AIMRC_CFG_RANGE_LSB +: 2];
            s_d.cfg.diff = pwdata[`AIMRC_CFG_DIFF_BIT];
            s_d.cfg.pseudo = pwdata[`AIMRC_CFG_PSEUDO_BIT];
            s_d.cfg.alloc = pwdata[`AIMRC_CFG_ALLOC_LSB +: 2];
            s_d.cfg.route = pwdata[`AIMRC_CFG_ROUTE_LSB +: 4];
        end

        // clear first so that a completion in the same cycle wins
        if (clr_req)
        begin
            s_d.done = 1'b0;
        end

        unique case (s_q.fsm)
            AIMRC_IDLE:
            begin
                // a start while busy is dropped; software polls busy first
                if (start_req)
                begin
                    s_d.act_range = s_q.cfg.range;
                    s_d.act_diff = s_q.cfg.diff;
                    s_d.fe.range = s_q.cfg.range;
                    s_d.fe.start = 1'b1;
                    s_d.fsm = AIMRC_LAUNCH;
                    if (s_q.cfg.diff)
                    begin
                        s_d.act_slot = pair;
                        s_d.fe.neg_gnd = 1'b0;
                        s_d.fe.step_units = 4'(mult << 1);
                        if (s_q.cfg.pseudo)
                        begin
                            // either pin of the pair may carry the signal
                            s_d.fe.pos_sel = {req_chan[0], s_q.cfg.alloc[req_chan[0]]};
                            s_d.fe.neg_sel = {req_chan[0], !s_q.cfg.alloc[req_chan[0]]};
                        end
                        else
                        begin
                            // pair 0: 0 positive, 1 negative; pair 1: 3 positive, 2 negative
                            s_d.fe.pos_sel = {req_chan[0], req_chan[0]};
                            s_d.fe.neg_sel = {req_chan[0], !req_chan[0]};
                        end
                    end
                    else
                    begin
                        s_d.act_slot = req_chan;
                        s_d.fe.pos_sel = req_chan;
                        s_d.fe.neg_sel = 2'b00;
                        s_d.fe.neg_gnd = 1'b1;
                        s_d.fe.step_units = mult;
                    end
                end
            end
            AIMRC_LAUNCH:
            begin
                s_d.fsm = AIMRC_WAIT;
            end
            AIMRC_WAIT:
            begin
                if (fe_done)
                begin
                    // core code is offset binary; flipping the top bit gives twos complement
                    if (s_q.act_diff)
                    begin
                        s_d.result[s_q.act_slot] = fe_code ^ `AIMRC_MIDSCALE;
                    end
                    else
                    begin
                        s_d.result[s_q.act_slot] = fe_code;
                    end
                    s_d.done = 1'b1;
                    s_d.fsm = AIMRC_IDLE;
                end
            end
            default:
            begin
                s_d.fsm = AIMRC_IDLE;
            end
        endcase

        for (int i = 0; i < 4; i++)
        begin
            if (is_valid[i])
            begin
                if (s_q.cfg.route[i])
                begin
                    s_d.loop_valid[i] = 1'b1;
                    s_d.loop_code[i] = is_code[i];
                end
                else
                begin
                    s_d.isense[i] = is_code[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.fsm <= AIMRC_IDLE;
            s_q.cfg.range <= `AIMRC_RANGE_RST;
            s_q.act_range <= `AIMRC_RANGE_RST;
            s_q.fe.range <= `AIMRC_RANGE_RST;
            s_q.fe.step_units <= `AIMRC_MULT_X4;
            s_q.fe.neg_gnd <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign fe_req = s_q.fe;
    assign loop_valid = s_q.loop_valid;
    assign loop_code = s_q.loop_code;

endmodule

`default_nettype wire

// ===== common/aimrc_cfg.svh
`ifndef AIMRC_CFG_SVH
`define AIMRC_CFG_SVH

// register byte offsets
`define AIMRC_OFF_CFG 8'h00
`define AIMRC_OFF_CTRL 8'h04
`define AIMRC_OFF_STATUS 8'h08
`define AIMRC_OFF_RESULT0 8'h10
`define AIMRC_OFF_RESULT3 8'h1c
`define AIMRC_OFF_ISENSE0 8'h20
`define AIMRC_OFF_ISENSE3 8'h2c

// configuration fields
`define AIMRC_CFG_RANGE_LSB 0
`define AIMRC_CFG_DIFF_BIT 2
`define AIMRC_CFG_PSEUDO_BIT 3
`define AIMRC_CFG_ALLOC_LSB 4
`define AIMRC_CFG_ROUTE_LSB 8

// control fields
`define AIMRC_CTRL_START_BIT 0
`define AIMRC_CTRL_CHAN_LSB 1
`define AIMRC_CTRL_CLR_BIT 3

// status fields
`define AIMRC_ST_BUSY_BIT 0
`define AIMRC_ST_DONE_BIT 1
`define AIMRC_ST_RANGE_LSB 2
`define AIMRC_ST_DIFF_BIT 4
`define AIMRC_ST_STEP_LSB 8

// reset values and codes
`define AIMRC_RANGE_RST 2'b00
`define AIMRC_RANGE_X4 2'b00
`define AIMRC_RANGE_X1 2'b11
`define AIMRC_MULT_X4 4'h4
`define AIMRC_MULT_X2 4'h2
`define AIMRC_MULT_X1 4'h1
`define AIMRC_MIDSCALE 12'h800
`define AIMRC_CODE_MIN 12'h000

`endif

// ===== common/aimrc_pkg.sv
`default_nettype none

package aimrc_pkg;

    typedef enum logic [2:0] {
        AIMRC_IDLE = 3'b001,
        AIMRC_LAUNCH = 3'b010,
        AIMRC_WAIT = 3'b100
    } aimrc_fsm_t;

    typedef struct packed {
        logic [3:0] route;
        logic [1:0] alloc;
        logic pseudo;
        logic diff;
        logic [1:0] range;
    } aimrc_cfg_t;

    // request handed to the analog converter core
    typedef struct packed {
        logic start;
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
        logic neg_gnd;
        logic [1:0] range;
        logic [3:0] step_units;
    } aimrc_fe_req_t;

    typedef struct packed {
        aimrc_fsm_t fsm;
        aimrc_cfg_t cfg;
        logic [1:0] act_range;
        logic act_diff;
        logic [1:0] act_slot;
        logic done;
        logic [3:0][11:0] result;
        logic [3:0][11:0] isense;
        logic [3:0] loop_valid;
        logic [3:0][11:0] loop_code;
        aimrc_fe_req_t fe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } aimrc_state_t;

endpackage

`default_nettype wire

// ===== test/aimrc_monitor.sv
`default_nettype none
module aimrc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire aimrc_pkg::aimrc_fe_req_t fe_req,
    input wire logic [3:0][11:0] is_code,
    input wire logic [3:0] loop_valid,
    input wire logic [3:0][11:0] loop_code
);
    timeunit 1ns;
    timeprecision 1ps;
    import aimrc_pkg::*;
    logic [3:0] mult;
    assign mult = fe_req.range == 2'b00 ? 4'h4 : fe_req.range == 2'b11 ? 4'h1 : 4'h2;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    property p_ans;
        s_acc |=> pready;
    endproperty
    a_ans: assert property (p_ans) else $error("late answer");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long answer");
    property p_err;
        pready && pslverr |-> paddr[1:0] != 2'b00 || paddr == 8'h0c || paddr > 8'h2c;
    endproperty
    a_err: assert property (p_err) else $error("error on mapped address");
    property p_start;
        fe_req.start |=> !fe_req.start;
    endproperty
    a_start: assert property (p_start) else $error("long start");
    property p_hold;
        !fe_req.start |=> fe_req.start || $stable(fe_req);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed");
    property p_step;
        fe_req.start |-> fe_req.step_units == (fe_req.neg_gnd ? mult : mult << 1);
    endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_pair;
        fe_req.start && !fe_req.neg_gnd |-> (fe_req.pos_sel ^ fe_req.neg_sel) == 2'b01;
    endproperty
    a_pair: assert property (p_pair) else $error("bad pair");
    property p_loop;
        loop_valid[1] |-> loop_code[1] == $past(is_code[1]);
    endproperty
    a_loop: assert property (p_loop) else $error("bad loop code");
endmodule
bind aimrc_top aimrc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .fe_req(fe_req),
    .is_code(is_code), .loop_valid(loop_valid), .loop_code(loop_code));
`default_nettype wire

// ===== test/aimrc_core_model.sv
`default_nettype none
module aimrc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire aimrc_pkg::aimrc_fe_req_t fe_req,
    input wire logic [3:0][11:0] analog_in,
    output logic fe_done,
    output logic [11:0] fe_code
);
    timeunit 1ns;
    timeprecision 1ps;
    import aimrc_pkg::*;
    logic [3:0] cnt;
    logic slow;
    logic [12:0] sd;
    assign sd = {1'b0, analog_in[fe_req.pos_sel]} - {1'b0, analog_in[fe_req.neg_sel]};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            slow <= 1'b0;
            fe_done <= 1'b0;
            fe_code <= 12'h5a5;
        end
        else
        begin
            fe_done <= cnt == 4'h1;
            // code toggles outside done so stale data is never mistaken for a result
            fe_code <= cnt != 4'h1 ? ~fe_code : fe_req.neg_gnd ? analog_in[fe_req.pos_sel]
                : sd[12:1] + 12'h800;
            cnt <= fe_req.start ? (slow ? 4'h9 : 4'h2) : cnt - {3'h0, cnt != 4'h0};
            slow <= slow ^ fe_req.start;
        end
    end
endmodule
`default_nettype wire

// ===== test/tb_aimrc_top.sv
`default_nettype none
module tb_aimrc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aimrc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    aimrc_fe_req_t fe_req;
    logic fe_done;
    logic [11:0] fe_code;
    logic [3:0] is_valid = 4'h0;
    logic [3:0][11:0] is_code = '0;
    logic [3:0] loop_valid;
    logic [3:0][11:0] loop_code;
    logic [3:0][11:0] analog_in = {12'hfff, 12'h001, 12'h800, 12'h000};
    logic [31:0] q;
    logic e;
    logic [31:0] c;
    logic [3:0] st;
    logic [1:0] p;
    logic [12:0] sd;
    int n_errors = 0;
    int check_count = 0;
    aimrc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fe_req(fe_req), .fe_done(fe_done), .fe_code(fe_code),
        .is_valid(is_valid), .is_code(is_code), .loop_valid(loop_valid),
        .loop_code(loop_code));
    aimrc_core_model core (.pclk(pclk), .presetn(presetn), .fe_req(fe_req),
        .analog_in(analog_in), .fe_done(fe_done), .fe_code(fe_code));
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("cfg reset", q, 32'h0);
        // modes: 0 single-ended, 1 differential, 2 pseudo-differential
        for (int m = 0; m < 3; m++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                c = {26'h0, m == 2 ? 2'b01 : 2'b00, m == 2, m > 0, r[1:0]};
                apb(1'b1, 8'h00, c);
                // clear the sticky done with the start so the poll below waits for this run
                apb(1'b1, 8'h04, {29'h1, r[1:0], 1'b1});
                apb(1'b1, 8'h00, c ^ 32'h7);
                q = 32'h0;
                for (int k = 0; k < 20 && q[1] !== 1'b1; k++)
                    apb(1'b0, 8'h08, 32'h0);
                st = r == 0 ? 4'h4 : r == 3 ? 4'h1 : 4'h2;
                if (m > 0)
                    st = st << 1;
                chk("status", q, {20'h0, st, 3'h0, m > 0, r[1:0], 2'b10});
                p = m == 1 ? (r[0] ? 2'd3 : 2'd0) : m == 2 ? (r[0] ? 2'd2 : 2'd1) : r[1:0];
                sd = {1'b0, analog_in[p]} - {1'b0, analog_in[p ^ 2'b01]};
                apb(1'b0, 8'h10 + {4'h0, m > 0 ? {1'b0, r[0]} : r[1:0], 2'b00}, 32'h0);
                chk("result", q, {20'h0, m == 0 ? analog_in[p] : sd[12:1]});
            end
        end
        apb(1'b1, 8'h00, 32'h200);
        is_code <= {24'h0, 12'habc, 12'h123};
        is_valid <= 4'h3;
        @(posedge pclk);
        is_valid <= 4'h0;
        @(posedge pclk);
        chk("loop valid", {28'h0, loop_valid}, 32'h2);
        apb(1'b0, 8'h20, 32'h0);
        chk("isense0", q, 32'h123);
        chk("loop1", {20'h0, loop_code[1]}, 32'habc);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped data", q, 32'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
